// ### pixel_thread_pkg.sv
// Constants, register map and state types for the pixel thread header builder.
// Assumes a single 20 MHz clock domain and an Avalon-MM host with byte addressing.

package pixel_thread_pkg;

   // ************************************************************
   // Widths
   // ************************************************************
   localparam int unsigned TAG_W  = 8;
   localparam int unsigned CNT_W  = 24;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 5;
   localparam int unsigned SCR_W  = 22;

   // ************************************************************
   // Register byte offsets
   // ************************************************************
   localparam logic [ADDR_W-1:0] OFS_CTRL    = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_SAMPLER = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_BINDING = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_SCRATCH = 5'h0c;
   localparam logic [ADDR_W-1:0] OFS_STATUS  = 5'h10;
   localparam logic [ADDR_W-1:0] OFS_THREAD  = 5'h14;

   // ************************************************************
   // Field positions and writable masks
   // ************************************************************
   localparam int unsigned CTRL_EN_BIT   = 0;
   localparam int unsigned STAT_INIT_BIT = 0;
   localparam int unsigned STAT_BUSY_BIT = 1;
   localparam int unsigned STAT_FREE_LSB = 8;
   localparam int unsigned SCR_PTR_LSB   = 10;
   localparam int unsigned ALLOW_MSB     = 3;
   localparam logic [DATA_W-1:0] CTRL_MASK    = 32'h0000_0001;
   localparam logic [DATA_W-1:0] SAMPLER_MASK = 32'hffff_ffef;
   localparam logic [DATA_W-1:0] BINDING_MASK = 32'hffff_ffe0;
   localparam logic [DATA_W-1:0] SCRATCH_MASK = 32'hffff_fc00;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [DATA_W-1:0] CFG_RST = 32'h0000_0000;
   localparam logic [CNT_W-1:0]  CNT_RST = 24'h00_0000;

   // ************************************************************
   // Header dword indices within payload register zero
   // ************************************************************
   localparam logic [2:0] DW_ZERO    = 3'h2;
   localparam logic [2:0] DW_SAMPLER = 3'h3;
   localparam logic [2:0] DW_BINDING = 3'h4;
   localparam logic [2:0] DW_SCRATCH = 3'h5;
   localparam logic [2:0] DW_THREAD  = 3'h6;
   localparam logic [2:0] DW_PRIM    = 3'h7;
   localparam logic [3:0] HDR_REG    = 4'h0;

   typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_TAG, ST_SEND} hdr_state_e;

endpackage

// ### tag_pool_ram.sv
// Simple dual-port memory holding the ring of free fused-thread tags.
// Assumes one clock; read data appear one cycle after rd_en, from a register.
`timescale 1ns/100ps

module tag_pool_ram #(
   parameter int unsigned WIDTH  = 8,
   parameter int unsigned ADDR_W = 8
) (
   input  wire logic              clk,      // System clock
   input  wire logic              wr_en,    // Write strobe
   input  wire logic [ADDR_W-1:0] wr_addr,  // Write address
   input  wire logic [WIDTH-1:0]  wr_data,  // Write data
   input  wire logic              rd_en,    // Read strobe
   input  wire logic [ADDR_W-1:0] rd_addr,  // Read address
   output logic      [WIDTH-1:0]  rd_data_q // Registered read data
);

   logic [WIDTH-1:0] mem [2**ADDR_W];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rd_en) begin
         rd_data_q <= mem[rd_addr];
      end
   end

endmodule

// ### pixel_thread_header_builder.sv
// Builds header dwords 2 to 7 of payload register zero for each fused pixel shader thread.
// Assumes an Avalon-MM host, a windowing source with valid/ready and a payload sink with ready.
//
// The Avalon-MM slave port and the register addresses were left to the implementer.
`timescale 1ns/100ps

module pixel_thread_header_builder #(
   parameter int unsigned TAG_W = pixel_thread_pkg::TAG_W,
   parameter int unsigned CNT_W = pixel_thread_pkg::CNT_W
) (
   input  wire logic                                clk,             // 20 MHz clock
   input  wire logic                                rst_n,           // Async reset, low
   input  wire logic [pixel_thread_pkg::ADDR_W-1:0] address,         // Avalon byte address
   input  wire logic                                read,            // Avalon read
   input  wire logic                                write,           // Avalon write
   input  wire logic [pixel_thread_pkg::DATA_W-1:0] writedata,       // Avalon write data
   input  wire logic [3:0]                          byteenable,      // Avalon byte enables
   output logic      [pixel_thread_pkg::DATA_W-1:0] readdata,        // Avalon read data
   output logic                                     waitrequest,     // Avalon wait
   input  wire logic                                disp_valid,      // Dispatch request
   input  wire logic [CNT_W-1:0]                    disp_prim_count, // Primitive thread count
   output logic                                     disp_ready,      // Dispatch accepted
   input  wire logic                                release_valid,   // Thread completed
   input  wire logic [TAG_W-1:0]                    release_tag,     // Tag of that thread
   output logic                                     pay_valid,       // Header dword valid
   input  wire logic                                pay_ready,       // Sink takes dword
   output logic      [pixel_thread_pkg::DATA_W-1:0] pay_data,        // Header dword
   output logic      [3:0]                          pay_reg,         // Payload register
   output logic      [2:0]                          pay_dword,       // Dword in register
   output logic                                     pay_last,        // Final dword
   output logic      [TAG_W-1:0]                    pay_tag          // Tag of this thread
);

   localparam int unsigned DEPTH = 2**TAG_W;
   localparam logic [TAG_W:0] FULL = (TAG_W+1)'(DEPTH);

   // ************************************************************
   // Header assembly
   // ************************************************************
   function automatic logic [31:0] hdr_dword(
      input logic [2:0]        idx,
      input logic [31:0]       smp,
      input logic [31:0]       bnd,
      input logic [21:0]       scr_kb,
      input logic [TAG_W-1:0]  tag,
      input logic [CNT_W-1:0]  tid,
      input logic [CNT_W-1:0]  prim
   );
      logic [31:0] d;
      d = 32'h0000_0000;
      unique case (idx)
         pixel_thread_pkg::DW_SAMPLER: d = smp & pixel_thread_pkg::SAMPLER_MASK;
         pixel_thread_pkg::DW_BINDING: d = bnd & pixel_thread_pkg::BINDING_MASK;
         pixel_thread_pkg::DW_SCRATCH: d = {scr_kb, 2'h0, 8'(tag)};
         pixel_thread_pkg::DW_THREAD:  d = {8'h00, 24'(tid)};
         pixel_thread_pkg::DW_PRIM:    d = {8'h00, 24'(prim)};
         default:                      d = 32'h0000_0000;
      endcase
      return d;
   endfunction

   function automatic logic [31:0] merge_be(
      input logic [31:0] old,
      input logic [31:0] nw,
      input logic [3:0]  be,
      input logic [31:0] mask
   );
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r & mask;
   endfunction

   // ************************************************************
   // Registers and state
   // ************************************************************
   pixel_thread_pkg::hdr_state_e state_q;
   logic [31:0]      ctrl_q;
   logic [31:0]      smp_q;
   logic [31:0]      bnd_q;
   logic [31:0]      scr_q;
   logic [31:0]      snap_smp_q;
   logic [31:0]      snap_bnd_q;
   logic [31:0]      snap_scr_q;
   logic [21:0]      scr_kb_q;
   logic [CNT_W-1:0] tid_cnt_q;
   logic [CNT_W-1:0] tid_q;
   logic [CNT_W-1:0] prim_q;
   logic [TAG_W-1:0] head_q;
   logic [TAG_W-1:0] tail_q;
   logic [TAG_W:0]   free_q;
   logic [TAG_W-1:0] pool_tag;
   logic             bus_req;
   logic             bus_acc;
   logic             init_wr;
   logic             rel_wr;
   logic             pool_wr;
   logic             pop;
   logic             accept;
   logic             pay_adv;
   logic [21:0]      scr_sum;

   assign bus_req = read | write;
   assign bus_acc = bus_req & ~waitrequest;
   assign init_wr = (state_q == pixel_thread_pkg::ST_INIT);
   // Releases during the fill are dropped: no tag can be out before the pool exists.
   assign rel_wr  = release_valid & ~init_wr & (free_q != FULL);
   assign pool_wr = init_wr | rel_wr;
   assign accept  = disp_valid & disp_ready;
   assign pop     = accept;
   assign pay_adv = pay_valid & pay_ready;
   // Scratch slots are laid out by tag; each slot is the per-thread allowance wide.
   assign scr_sum = snap_scr_q[31:pixel_thread_pkg::SCR_PTR_LSB]
                  + 22'({14'h0000, pool_tag} << snap_smp_q[pixel_thread_pkg::ALLOW_MSB:0]);

   tag_pool_ram #(
      .WIDTH  (TAG_W),
      .ADDR_W (TAG_W)
   ) u_pool (
      .clk       (clk),
      .wr_en     (pool_wr),
      .wr_addr   (tail_q),
      .wr_data   (init_wr ? tail_q : release_tag),
      .rd_en     (pop),
      .rd_addr   (head_q),
      .rd_data_q (pool_tag)
   );

   // ************************************************************
   // Avalon-MM slave: one wait cycle, then the answer
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= ~(bus_req & waitrequest);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         readdata <= 32'h0000_0000;
      end else if (read & waitrequest) begin
         unique case (address)
            pixel_thread_pkg::OFS_CTRL:    readdata <= ctrl_q;
            pixel_thread_pkg::OFS_SAMPLER: readdata <= smp_q;
            pixel_thread_pkg::OFS_BINDING: readdata <= bnd_q;
            pixel_thread_pkg::OFS_SCRATCH: readdata <= scr_q;
            pixel_thread_pkg::OFS_STATUS:  readdata <= 32'({free_q, 6'h00,
                                              (state_q != pixel_thread_pkg::ST_IDLE), ~init_wr});
            pixel_thread_pkg::OFS_THREAD:  readdata <= 32'(tid_cnt_q);
            default:                       readdata <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= pixel_thread_pkg::CFG_RST;
         smp_q  <= pixel_thread_pkg::CFG_RST;
         bnd_q  <= pixel_thread_pkg::CFG_RST;
         scr_q  <= pixel_thread_pkg::CFG_RST;
      end else if (write & bus_acc) begin
         unique case (address)
            pixel_thread_pkg::OFS_CTRL:
               ctrl_q <= merge_be(ctrl_q, writedata, byteenable, pixel_thread_pkg::CTRL_MASK);
            pixel_thread_pkg::OFS_SAMPLER:
               smp_q <= merge_be(smp_q, writedata, byteenable, pixel_thread_pkg::SAMPLER_MASK);
            pixel_thread_pkg::OFS_BINDING:
               bnd_q <= merge_be(bnd_q, writedata, byteenable, pixel_thread_pkg::BINDING_MASK);
            pixel_thread_pkg::OFS_SCRATCH:
               scr_q <= merge_be(scr_q, writedata, byteenable, pixel_thread_pkg::SCRATCH_MASK);
            default: ;
         endcase
      end
   end

   // ************************************************************
   // Free tag ring
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tail_q <= '0;
      end else if (pool_wr) begin
         tail_q <= tail_q + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         head_q <= '0;
      end else if (pop) begin
         head_q <= head_q + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         free_q <= '0;
      end else begin
         free_q <= free_q + (TAG_W+1)'(pool_wr) - (TAG_W+1)'(pop);
      end
   end

   // ************************************************************
   // Dispatch sequencing
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= pixel_thread_pkg::ST_INIT;
      end else begin
         unique case (state_q)
            pixel_thread_pkg::ST_INIT:
               if (tail_q == TAG_W'(DEPTH - 1)) begin
                  state_q <= pixel_thread_pkg::ST_IDLE;
               end
            pixel_thread_pkg::ST_IDLE:
               if (accept) begin
                  state_q <= pixel_thread_pkg::ST_TAG;
               end
            pixel_thread_pkg::ST_TAG:
               state_q <= pixel_thread_pkg::ST_SEND;
            pixel_thread_pkg::ST_SEND:
               if (pay_adv && pay_last) begin
                  state_q <= pixel_thread_pkg::ST_IDLE;
               end
         endcase
      end
   end

   // Ready is offered only while idle, enabled and a tag is free, so a popped tag is always real.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         disp_ready <= 1'b0;
      end else begin
         disp_ready <= (state_q == pixel_thread_pkg::ST_IDLE) & ~accept
                     & ctrl_q[pixel_thread_pkg::CTRL_EN_BIT] & (free_q != '0);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tid_cnt_q <= pixel_thread_pkg::CNT_RST;
      end else if (accept) begin
         tid_cnt_q <= tid_cnt_q + 1'b1;
      end
   end

   // Configuration is frozen at acceptance so a register write cannot tear a header.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tid_q      <= pixel_thread_pkg::CNT_RST;
         prim_q     <= pixel_thread_pkg::CNT_RST;
         snap_smp_q <= pixel_thread_pkg::CFG_RST;
         snap_bnd_q <= pixel_thread_pkg::CFG_RST;
         snap_scr_q <= pixel_thread_pkg::CFG_RST;
      end else if (accept) begin
         tid_q      <= tid_cnt_q;
         prim_q     <= disp_prim_count;
         snap_smp_q <= smp_q;
         snap_bnd_q <= bnd_q;
         snap_scr_q <= scr_q;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scr_kb_q <= '0;
      end else if (state_q == pixel_thread_pkg::ST_TAG) begin
         scr_kb_q <= scr_sum;
      end
   end

   // ************************************************************
   // Payload output
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pay_valid <= 1'b0;
         pay_dword <= pixel_thread_pkg::DW_ZERO;
         pay_last  <= 1'b0;
         pay_data  <= 32'h0000_0000;
         pay_reg   <= pixel_thread_pkg::HDR_REG;
      end else if (state_q == pixel_thread_pkg::ST_TAG) begin
         pay_valid <= 1'b1;
         pay_reg   <= pixel_thread_pkg::HDR_REG;
         pay_dword <= pixel_thread_pkg::DW_ZERO;
         pay_last  <= 1'b0;
         pay_data  <= 32'h0000_0000;
      end else if (pay_adv) begin
         // Dwords follow one another with no hole in between.
         pay_valid <= ~pay_last;
         pay_dword <= pay_last ? pixel_thread_pkg::DW_ZERO : pay_dword + 1'b1;
         pay_last  <= (pay_dword + 1'b1 == pixel_thread_pkg::DW_PRIM);
         pay_data  <= pay_last ? 32'h0000_0000
                    : hdr_dword(pay_dword + 1'b1, snap_smp_q, snap_bnd_q, scr_kb_q,
                                pay_tag, tid_q, prim_q);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pay_tag <= '0;
      end else if (state_q == pixel_thread_pkg::ST_TAG) begin
         pay_tag <= pool_tag;
      end
   end

endmodule

// ### hdr_sink_model.sv
// Model of the shader thread that takes the header dwords.
// Assumes the builder's valid/ready payload port on one clock.
`timescale 1ns/100ps
module hdr_sink_model (
   input  wire logic        clk,       // Clock
   input  wire logic        rst_n,     // Reset, low
   input  wire logic        slow,      // Stall every other cycle
   input  wire logic        pay_valid, // Dword offered
   input  wire logic [31:0] pay_data,  // Dword
   input  wire logic [2:0]  pay_dword, // Dword index
   input  wire logic        pay_last,  // Final dword
   output logic             pay_ready, // Dword taken
   output logic [31:0]      hdr_q [8], // Captured header
   output int               done_q     // Headers received
);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pay_ready <= 1'b0;
      end else begin
         pay_ready <= slow ? ~pay_ready : 1'b1;
      end
   end

   // The allowance is kept verbatim and never decoded, as a data port would ignore it.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hdr_q  <= '{default: 32'hffff_ffff};
         done_q <= 0;
      end else if (pay_valid && pay_ready) begin
         hdr_q[pay_dword] <= pay_data;
         if (pay_last) begin
            done_q <= done_q + 1;
         end
      end
   end
endmodule

// ### header_builder_asserts.sv
// Checker for the header builder's dispatch and payload ports.
// Assumes one clock domain; bound to the design at the foot of this file.
`timescale 1ns/100ps
module header_builder_asserts #(
   parameter int unsigned TAG_W = 8,
   parameter int unsigned CNT_W = 24
) (
   input wire logic                                clk,        // Clock
   input wire logic                                rst_n,      // Reset, low
   input wire logic                                disp_valid, // Dispatch request
   input wire logic                                disp_ready, // Dispatch taken
   input wire logic                                pay_valid,  // Dword valid
   input wire logic                                pay_ready,  // Dword taken
   input wire logic [pixel_thread_pkg::DATA_W-1:0] pay_data,   // Dword
   input wire logic [3:0]                          pay_reg,    // Register
   input wire logic [2:0]                          pay_dword,  // Dword index
   input wire logic                                pay_last,   // Final dword
   input wire logic [TAG_W-1:0]                    pay_tag     // Thread tag
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_reg_zero: assert property (pay_valid |-> pay_reg == 4'h0)
      else $error("header not in register zero");
   chk_dword_step: assert property (pay_valid && pay_ready && !pay_last
      |=> pay_dword == $past(pay_dword) + 3'h1) else $error("dword order gap");
   chk_first_zero: assert property (disp_valid && disp_ready
      |-> ##2 pay_valid && pay_dword == 3'h2 && pay_data == 32'h0)
      else $error("dword 2 not first or not zero");
   chk_prim_resv: assert property (pay_valid && pay_dword == 3'h7
      |-> pay_last && pay_data[31:24] == 8'h00) else $error("dword 7 bad");
   chk_tid_resv: assert property (pay_valid && pay_dword == 3'h6
      |-> pay_data[31:24] == 8'h00 && !pay_last) else $error("dword 6 bad");
   chk_tag_field: assert property (pay_valid && pay_dword == 3'h5
      |-> pay_data[9:8] == 2'b00 && pay_data[TAG_W-1:0] == pay_tag)
      else $error("dword 5 tag bad");
   chk_bind_resv: assert property (pay_valid && pay_dword == 3'h4
      |-> pay_data[4:0] == 5'h00) else $error("dword 4 reserved set");
   chk_smp_resv: assert property (pay_valid && pay_dword == 3'h3
      |-> pay_data[4] == 1'b0) else $error("dword 3 reserved set");
   chk_stall_hold: assert property (pay_valid && !pay_ready
      |=> pay_valid && $stable(pay_data) && $stable(pay_dword))
      else $error("dword changed while stalled");
   chk_one_thread: assert property (disp_valid && disp_ready
      |=> !disp_ready[*3]) else $error("dispatch taken twice");
endmodule

bind pixel_thread_header_builder header_builder_asserts #(.TAG_W(TAG_W), .CNT_W(CNT_W)) chk_i (
   .clk(clk), .rst_n(rst_n), .disp_valid(disp_valid), .disp_ready(disp_ready),
   .pay_valid(pay_valid), .pay_ready(pay_ready), .pay_data(pay_data), .pay_reg(pay_reg),
   .pay_dword(pay_dword), .pay_last(pay_last), .pay_tag(pay_tag));

// ### tb_top.sv
// Self-checking bench for the pixel thread header builder.
// Assumes the sink model and the bound checker; bus is Avalon-MM.
`timescale 1ns/100ps
module tb_top;
   logic        clk, rst_n, rd, wr, wreq, dv, dr, rel_v, slow, pv, pr, pl;
   logic [4:0]  addr;
   logic [31:0] wdata, rdata, pd;
   logic [23:0] prim;
   logic [3:0]  preg;
   logic [2:0]  pdw;
   logic [7:0]  rel_tag, ptag;
   logic [31:0] hdr [8];
   int          done, fail_count, samples_checked, cycles;

   pixel_thread_header_builder uut (.clk(clk), .rst_n(rst_n), .address(addr), .read(rd),
      .write(wr), .writedata(wdata), .byteenable(4'hf), .readdata(rdata), .waitrequest(wreq),
      .disp_valid(dv), .disp_prim_count(prim), .disp_ready(dr), .release_valid(rel_v),
      .release_tag(rel_tag), .pay_valid(pv), .pay_ready(pr), .pay_data(pd), .pay_reg(preg),
      .pay_dword(pdw), .pay_last(pl), .pay_tag(ptag));
   hdr_sink_model sink (.clk(clk), .rst_n(rst_n), .slow(slow), .pay_valid(pv),
      .pay_data(pd), .pay_dword(pdw), .pay_last(pl), .pay_ready(pr), .hdr_q(hdr),
      .done_q(done));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // The request is held until waitrequest is seen low at a rising edge and dropped right there.
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge clk);
      addr  <= a;
      wr    <= w;
      rd    <= !w;
      wdata <= d;
      do @(posedge clk);
      while (wreq !== 1'b0);
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   task automatic wreg(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rchk(input string what, input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(what, exp, q);
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_regs();
      logic [4:0]  a [5] = '{pixel_thread_pkg::OFS_SAMPLER, pixel_thread_pkg::OFS_BINDING,
                             pixel_thread_pkg::OFS_SCRATCH, pixel_thread_pkg::OFS_THREAD, 5'h18};
      logic [31:0] m [5] = '{32'hffff_ffef, 32'hffff_ffe0, 32'hffff_fc00, 32'h0, 32'h0};
      logic [31:0] q;
      for (int k = 0; k < 5; k++) begin
         rchk("reg reset", a[k], 32'h0);
         wreg(a[k], 32'hffff_ffff);
         rchk("reg mask", a[k], m[k]);
      end
      q = 32'h0;
      while (q[0] !== 1'b1) bus(1'b0, pixel_thread_pkg::OFS_STATUS, 32'h0, q);
      chk("pool full", 32'h0001_0001, q);
      wreg(pixel_thread_pkg::OFS_SCRATCH, 32'h1234_5400);
      wreg(pixel_thread_pkg::OFS_CTRL, 32'h1);
      $display("register test done");
   endtask

   task automatic t_thread(input int i);
      logic [31:0] s, b;
      logic [21:0] sp;
      logic [23:0] p;
      s  = 32'hfedc_ba90 | 32'(i);
      b  = 32'h89ab_cd1f ^ (32'(i) << 8);
      p  = 24'hff_ffff - 24'(i);
      sp = 22'h04_8d15 + (22'(i) << i);
      slow <= i[0];
      wreg(pixel_thread_pkg::OFS_SAMPLER, s);
      wreg(pixel_thread_pkg::OFS_BINDING, b);
      @(posedge clk);
      dv   <= 1'b1;
      prim <= p;
      do @(posedge clk);
      while (dr !== 1'b1);
      dv <= 1'b0;
      do @(negedge clk);
      while (done != i + 1);
      chk("dword2", 32'h0, hdr[2]);
      chk("dword3", s & 32'hffff_ffef, hdr[3]);
      chk("dword4", b & 32'hffff_ffe0, hdr[4]);
      chk("dword5", {sp, 2'b00, 8'(i)}, hdr[5]);
      chk("dword6", {8'h00, 24'(i)}, hdr[6]);
      chk("dword7", {8'h00, p}, hdr[7]);
      rchk("thread count", pixel_thread_pkg::OFS_THREAD, 32'(i + 1));
      $display("thread %0d done", i);
   endtask

   task automatic t_release();
      rchk("free before", pixel_thread_pkg::OFS_STATUS, 32'h0000_f401);
      @(posedge clk);
      rel_v   <= 1'b1;
      rel_tag <= 8'h05;
      @(posedge clk);
      rel_v <= 1'b0;
      rchk("free after", pixel_thread_pkg::OFS_STATUS, 32'h0000_f501);
      $display("release test done");
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         $display("BAD watchdog expected finish seen timeout");
         wrap_up();
      end
   end

   initial begin
      {rst_n, rd, wr, dv, rel_v, slow} = '0;
      {addr, wdata, prim, rel_tag} = '0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      for (int i = 0; i < 12; i++) t_thread(i);
      t_release();
      wrap_up();
   end
endmodule
